/* include/srm_defs.svh */
// Constants for the SGMII bridge rate and management register block
// Functional notes
// - The operational rate output uses 10 for 1 Gbps, 01 for 100 Mbps and 00 for 10 Mbps.
// - In SGMII with negotiation off the manual rate is used; with it on, MAC takes the partner rate and PHY the advertised rate; 1000BASE-X always gives 1 Gbps.
// - Control (0x0) and advertised ability (0x4) are read/write (0x4 fixed for SGMII MAC); status, partner, expansion and extended status are read-only.
// - In the classic build the registers are reached by Clause 22 MDIO frames.
// - In the alternative build the same registers are reached by a parallel host bus.
// - Control bit 15 resets the channel when written 1 and clears itself.
// - Control bits 6 and 13 form the speed select: 10 is 1 Gbps, 01 100 Mbps, 00 10 Mbps, 11 reserved.
// - In 1000BASE-X mode the speed select reads 1 Gbps and ignores writes.
// - In SGMII mode the speed select takes any value and sets the rate only with negotiation off.
// - In SGMII with negotiation on the rate follows bits 11:10 of the advertised ability in the PHY role and of the partner ability in the MAC role.
// - Control bit 11 set powers the channel down, cleared powers it up.
// - Control bit 9 restarts negotiation when written 1 without bit 15 in the same write, and clears itself.
// - The MAC or PHY role comes from a pin and feeds the rate resolver.
// - The PCS standard select may change at run time and feeds the rate resolver.
// - Status bit 2 shows link up, latches 0 on link loss and clears on read.
`ifndef SRM_DEFS_SVH
`define SRM_DEFS_SVH
`define SRM_OFS_CTRL 5'h00
`define SRM_OFS_STAT 5'h01
`define SRM_OFS_ADV 5'h04
`define SRM_OFS_LPA 5'h05
`define SRM_OFS_EXP 5'h06
`define SRM_OFS_EXT 5'h0f
`define SRM_B_RESET 15
`define SRM_B_LOOP 14
`define SRM_B_SPD0 13
`define SRM_B_ANEN 12
`define SRM_B_PWDN 11
`define SRM_B_ISO 10
`define SRM_B_RESTART 9
`define SRM_B_SPD1 6
`define SRM_B_LINK 2
`define SRM_CTRL_WMASK 16'h7d60
`define SRM_SPD_MASK 16'h2040
`define SRM_CTRL_RST 16'h1140
`define SRM_ADV_RST 16'h0801
`define SRM_ADV_MAC 16'h4001
`define SRM_EXT_VAL 16'h8000
`define SRM_UNIDIR_CAP 1'b1
`define SRM_RATE_1G 2'b10
`define SRM_RATE_100M 2'b01
`define SRM_RATE_10M 2'b00
`define SRM_OP_WR 2'b01
`define SRM_OP_RD 2'b10
`define SRM_PRE_LEN 6'h20
`define SRM_HDR_LAST 4'hc
`define SRM_DATA_LAST 4'hf
`endif

/* include/srm_pkg.sv */
// Types shared by the management register block
package srm_pkg;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [4:0] addr;
		logic [15:0] wdata;
	} srm_req_t;
	typedef enum logic [1:0] {
		SRM_IDLE = 2'b00,
		SRM_HDR = 2'b01,
		SRM_TA = 2'b11,
		SRM_DATA = 2'b10
	} srm_mdio_st_t;
endpackage

/* hdl/srm_mdio_slave.sv */
// Clause 22 serial management frame engine
`timescale 1ns/1ps
`include "srm_defs.svh"
module srm_mdio_slave (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic mdc_s,
	input wire logic mdio_s,
	input wire logic [4:0] phy_addr,
	input wire logic [15:0] rd_data,
	output srm_pkg::srm_req_t req,
	output logic mdio_o,
	output logic mdio_oe_n
);
	srm_pkg::srm_mdio_st_t state_r;
	logic mdc_d_r;
	logic [5:0] pre_r;
	logic [3:0] cnt_r;
	logic [15:0] sh_r;
	logic rd_op_r;
	wire rise = mdc_s & ~mdc_d_r;
	wire [13:0] hdr = {sh_r[12:0], mdio_s};
	wire op_ok = (hdr[11:10] == `SRM_OP_RD) || (hdr[11:10] == `SRM_OP_WR);
	wire hdr_ok = (hdr[13:12] == 2'b01) && op_ok && (hdr[9:5] == phy_addr);

	// Sampling on the rising edge of the management clock, as the station does
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= srm_pkg::SRM_IDLE;
			mdc_d_r <= 1'b0;
			pre_r <= 6'h00;
			cnt_r <= 4'h0;
			sh_r <= 16'h0000;
			rd_op_r <= 1'b0;
			req <= '0;
			mdio_o <= 1'b1;
			mdio_oe_n <= 1'b1;
		end else begin
			mdc_d_r <= mdc_s;
			req.wr <= 1'b0;
			req.rd <= 1'b0;
			if (rise) begin
				case (state_r)
				srm_pkg::SRM_IDLE: begin
					if (mdio_s) begin
						if (pre_r != `SRM_PRE_LEN)
							pre_r <= pre_r + 6'h01;
					end else begin
						if (pre_r == `SRM_PRE_LEN) begin
							state_r <= srm_pkg::SRM_HDR;
							cnt_r <= 4'h0;
							sh_r <= 16'h0000;
						end
						pre_r <= 6'h00;
					end
				end
				srm_pkg::SRM_HDR: begin
					sh_r <= {sh_r[14:0], mdio_s};
					cnt_r <= cnt_r + 4'h1;
					if (cnt_r == `SRM_HDR_LAST) begin
						cnt_r <= 4'h0;
						// Frames for another address leave the pin alone
						if (hdr_ok) begin
							state_r <= srm_pkg::SRM_TA;
							rd_op_r <= (hdr[11:10] == `SRM_OP_RD);
							req.addr <= hdr[4:0];
						end else begin
							state_r <= srm_pkg::SRM_IDLE;
						end
					end
				end
				srm_pkg::SRM_TA: begin
					cnt_r <= cnt_r + 4'h1;
					if (cnt_r == 4'h0) begin
						if (rd_op_r) begin
							mdio_oe_n <= 1'b0;
							mdio_o <= 1'b0;
						end
					end else begin
						state_r <= srm_pkg::SRM_DATA;
						cnt_r <= 4'h0;
						if (rd_op_r) begin
							sh_r <= rd_data;
							mdio_o <= rd_data[15];
							req.rd <= 1'b1;
						end
					end
				end
				srm_pkg::SRM_DATA: begin
					cnt_r <= cnt_r + 4'h1;
					if (rd_op_r) begin
						mdio_o <= sh_r[14];
						sh_r <= {sh_r[14:0], 1'b0};
					end else begin
						sh_r <= {sh_r[14:0], mdio_s};
					end
					if (cnt_r == `SRM_DATA_LAST) begin
						state_r <= srm_pkg::SRM_IDLE;
						mdio_oe_n <= 1'b1;
						mdio_o <= 1'b1;
						if (!rd_op_r) begin
							req.wr <= 1'b1;
							req.wdata <= {sh_r[14:0], mdio_s};
						end
					end
				end
				default: state_r <= srm_pkg::SRM_IDLE;
				endcase
			end
		end
	end
endmodule

/* hdl/srm_rate_mgmt_top.sv */
// Management registers and rate resolver of the SGMII bridge
`timescale 1ns/1ps
`include "srm_defs.svh"
module srm_rate_mgmt_top #(
	parameter bit HOST_BUS = 1'b0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic mdc,
	input wire logic mdio_i,
	output logic mdio_o,
	output logic mdio_oe_n,
	input wire logic [4:0] phy_addr,
	input wire srm_pkg::srm_req_t hb_req,
	output logic [15:0] hb_rdata,
	input wire logic sgmii_phy_role,
	input wire logic pcs_standard_select,
	input wire logic link_up,
	input wire logic an_complete,
	input wire logic [15:0] partner_ability,
	input wire logic [15:0] an_expansion,
	output logic [1:0] operational_rate,
	output logic channel_reset,
	output logic an_restart,
	output logic loopback,
	output logic an_enable,
	output logic power_down,
	output logic isolate,
	output logic [15:0] advertised_ability
);
	logic [1:0] rst_sync_r;
	logic [8:0] pin_m_r;
	logic [8:0] pin_s_r;
	logic rst_s;
	logic [15:0] ctrl_r;
	logic [15:0] adv_r;
	logic lstat_r;
	logic [1:0] rate_r;
	logic rst_pulse_r;
	logic restart_r;
	logic [15:0] rd_data;
	logic [15:0] ctrl_rd;
	logic [15:0] stat_rd;
	logic [15:0] adv_rd;
	srm_pkg::srm_req_t m_req;
	srm_pkg::srm_req_t req;
	logic m_mdio_o;
	logic m_oe_n;

	// Reset release through two flip-flops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			rst_sync_r <= 2'b00;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	end
	assign rst_s = rst_sync_r[1];

	// Pins from outside the clock domain; only the second stage is read
	always_ff @(posedge clk or negedge rst_s) begin
		if (!rst_s) begin
			pin_m_r <= 9'h000;
			pin_s_r <= 9'h000;
		end else begin
			pin_m_r <= {mdc, mdio_i, sgmii_phy_role, pcs_standard_select, phy_addr};
			pin_s_r <= pin_m_r;
		end
	end
	wire mdc_s = pin_s_r[8];
	wire mdio_s = pin_s_r[7];
	wire role_phy = pin_s_r[6];
	wire std_x = pin_s_r[5];
	wire [4:0] phy_addr_s = pin_s_r[4:0];

	srm_mdio_slave srm_mdio_slave_i (
		.clk(clk),
		.rst_n(rst_s),
		.mdc_s(mdc_s),
		.mdio_s(mdio_s),
		.phy_addr(phy_addr_s),
		.rd_data(rd_data),
		.req(m_req),
		.mdio_o(m_mdio_o),
		.mdio_oe_n(m_oe_n)
	);

	// One register set, reached either serially or by the host bus
	assign req = HOST_BUS ? hb_req : m_req;
	assign mdio_o = HOST_BUS ? 1'b1 : m_mdio_o;
	assign mdio_oe_n = HOST_BUS ? 1'b1 : m_oe_n;

	// Write and status read decode
	wire wr_ctrl = req.wr && (req.addr == `SRM_OFS_CTRL);
	wire wr_adv = req.wr && (req.addr == `SRM_OFS_ADV);
	wire rd_stat = req.rd && (req.addr == `SRM_OFS_STAT);
	wire do_reset = wr_ctrl && req.wdata[`SRM_B_RESET];
	wire do_restart = wr_ctrl && req.wdata[`SRM_B_RESTART] && !do_reset;
	// A MAC-side SGMII link sends a fixed word, so writes there are dropped
	wire adv_fixed = !std_x && !role_phy;
	wire [15:0] ctrl_wmask = std_x ? (`SRM_CTRL_WMASK & ~`SRM_SPD_MASK) : `SRM_CTRL_WMASK;

	// Control and advertised ability storage
	always_ff @(posedge clk or negedge rst_s) begin
		if (!rst_s) begin
			ctrl_r <= `SRM_CTRL_RST;
			adv_r <= `SRM_ADV_RST;
		end else if (do_reset) begin
			ctrl_r <= `SRM_CTRL_RST;
			adv_r <= `SRM_ADV_RST;
		end else begin
			if (wr_ctrl)
				ctrl_r <= (ctrl_r & ~ctrl_wmask) | (req.wdata & ctrl_wmask);
			if (wr_adv && !adv_fixed)
				adv_r <= req.wdata;
		end
	end

	// Self-clearing bits never store; they leave as one-cycle pulses
	always_ff @(posedge clk or negedge rst_s) begin
		if (!rst_s) begin
			rst_pulse_r <= 1'b0;
			restart_r <= 1'b0;
		end else begin
			rst_pulse_r <= do_reset;
			restart_r <= do_restart;
		end
	end

	// Link status latches low; a loss in the reading cycle is still kept
	always_ff @(posedge clk or negedge rst_s) begin
		if (!rst_s)
			lstat_r <= 1'b0;
		else if (!link_up)
			lstat_r <= 1'b0;
		else if (rd_stat)
			lstat_r <= 1'b1;
	end

	// Speed select reads fixed 1 Gbps in 1000BASE-X
	wire spd1 = std_x ? 1'b1 : ctrl_r[`SRM_B_SPD1];
	wire spd0 = std_x ? 1'b0 : ctrl_r[`SRM_B_SPD0];
	wire [1:0] manual_rate_setting = {ctrl_r[`SRM_B_SPD1], ctrl_r[`SRM_B_SPD0]};
	wire [1:0] advertised_rate_field = adv_r[11:10];
	wire [1:0] partner_rate_field = partner_ability[11:10];

	assign ctrl_rd = {1'b0, ctrl_r[14], spd0, ctrl_r[12:10], 1'b0, ctrl_r[8], 1'b0, spd1, ctrl_r[5], 5'h00};
	assign stat_rd = {7'h00, 1'b1, `SRM_UNIDIR_CAP, 1'b0, an_complete, 1'b0, 1'b1, lstat_r, 2'b00};
	assign adv_rd = adv_fixed ? `SRM_ADV_MAC : adv_r;

	// Read select; unmapped addresses read zero
	always_comb begin
		case (req.addr)
		`SRM_OFS_CTRL: rd_data = ctrl_rd;
		`SRM_OFS_STAT: rd_data = stat_rd;
		`SRM_OFS_ADV: rd_data = adv_rd;
		`SRM_OFS_LPA: rd_data = partner_ability;
		`SRM_OFS_EXP: rd_data = an_expansion;
		`SRM_OFS_EXT: rd_data = `SRM_EXT_VAL;
		default: rd_data = 16'h0000;
		endcase
	end

	// Host bus read data, one cycle after the strobe
	always_ff @(posedge clk or negedge rst_s) begin
		if (!rst_s)
			hb_rdata <= 16'h0000;
		else if (HOST_BUS && hb_req.rd)
			hb_rdata <= rd_data;
	end

	// Rate resolver; the 1000BASE-X term comes first so a mode change wins at once
	wire [1:0] rate_nxt = std_x ? `SRM_RATE_1G :
		!ctrl_r[`SRM_B_ANEN] ? manual_rate_setting :
		role_phy ? advertised_rate_field : partner_rate_field;

	always_ff @(posedge clk or negedge rst_s) begin
		if (!rst_s)
			rate_r <= `SRM_RATE_1G;
		else
			rate_r <= rate_nxt;
	end

	assign operational_rate = rate_r;
	assign channel_reset = rst_pulse_r;
	assign an_restart = restart_r;
	assign loopback = ctrl_r[`SRM_B_LOOP];
	assign an_enable = ctrl_r[`SRM_B_ANEN];
	assign power_down = ctrl_r[`SRM_B_PWDN];
	assign isolate = ctrl_r[`SRM_B_ISO];
	assign advertised_ability = adv_rd;

	a_rate_gbe_fixed: assert property (@(posedge clk) disable iff (!rst_s)
		std_x |=> operational_rate == `SRM_RATE_1G)
		else $error("rate not 1G in 1000BASE-X mode");

	a_rate_manual_sel: assert property (@(posedge clk) disable iff (!rst_s)
		(!std_x && !ctrl_r[`SRM_B_ANEN]) |=> operational_rate == $past(manual_rate_setting))
		else $error("manual rate not used with negotiation off");

	a_rate_phy_adv: assert property (@(posedge clk) disable iff (!rst_s)
		(!std_x && ctrl_r[`SRM_B_ANEN] && role_phy) |=> operational_rate == $past(adv_r[11:10]))
		else $error("PHY role rate not from advertised ability");

	a_rate_mac_partner: assert property (@(posedge clk) disable iff (!rst_s)
		(!std_x && ctrl_r[`SRM_B_ANEN] && !role_phy) |=> operational_rate == $past(partner_ability[11:10]))
		else $error("MAC role rate not from partner ability");

	a_speed_gbe_read: assert property (@(posedge clk) disable iff (!rst_s)
		std_x |-> (ctrl_rd[`SRM_B_SPD1] && !ctrl_rd[`SRM_B_SPD0]))
		else $error("speed select not stuck at 1G");

	a_ro_no_store: assert property (@(posedge clk) disable iff (!rst_s)
		(req.wr && req.addr != `SRM_OFS_ADV && !do_reset) |=> $stable(adv_r))
		else $error("write to other offset changed advertised ability");

	a_reset_self_clr: assert property (@(posedge clk) disable iff (!rst_s)
		do_reset |=> (channel_reset && ctrl_r == `SRM_CTRL_RST) ##1 !channel_reset)
		else $error("channel reset not a self-clearing pulse");

	a_restart_self_clr: assert property (@(posedge clk) disable iff (!rst_s)
		do_restart |=> an_restart ##1 !an_restart)
		else $error("restart not a self-clearing pulse");

	a_power_down_wr: assert property (@(posedge clk) disable iff (!rst_s)
		(wr_ctrl && !do_reset) |=> power_down == $past(req.wdata[`SRM_B_PWDN]))
		else $error("power down bit not written");

	a_link_latch_low: assert property (@(posedge clk) disable iff (!rst_s)
		!link_up |=> !lstat_r ##1 (lstat_r || !$past(rd_stat) || !$past(link_up)))
		else $error("link status latch wrong");

	a_link_read_set: assert property (@(posedge clk) disable iff (!rst_s)
		(rd_stat && link_up) |=> lstat_r)
		else $error("link status not reloaded by read");

	a_adv_write: assert property (@(posedge clk) disable iff (!rst_s)
		(wr_adv && !adv_fixed) |=> adv_r == $past(req.wdata))
		else $error("advertised ability write lost");
endmodule

/* dv/srm_station_mgr.sv */
// Station manager model driving the parallel host bus
`timescale 1ns/1ps
module srm_station_mgr (
	input wire logic clk,
	output srm_pkg::srm_req_t req,
	input wire logic [15:0] rdata,
	output logic mdc,
	output logic mdio,
	input wire logic dev_o,
	input wire logic dev_oe_n
);
	logic st_en = 1'b0;
	logic st_bit = 1'b1;
	initial req = '0;
	initial mdc = 1'b0;
	// Pull-up holds the line high when neither side drives it
	assign mdio = !dev_oe_n ? dev_o : (st_en ? st_bit : 1'b1);
	// One serial frame; bits change while the clock is low and are sampled as it rises
	task automatic mdio_xfer(input logic rd_op, input logic [4:0] pa, input logic [4:0] ra,
		input logic [15:0] wd, output logic [15:0] d);
		logic [63:0] f;
		logic [63:0] en;
		f = {32'hffff_ffff, 2'b01, (rd_op ? 2'b10 : 2'b01), pa, ra,
			(rd_op ? 2'b11 : 2'b10), (rd_op ? 16'hffff : wd)};
		en = rd_op ? {{46{1'b1}}, 18'h0_0000} : {64{1'b1}};
		d = 16'h0000;
		for (int k = 63; k >= 0; k--) begin
			@(posedge clk);
			mdc <= 1'b0;
			st_en <= en[k];
			st_bit <= f[k];
			repeat (4) @(posedge clk);
			mdc <= 1'b1;
			d = {d[14:0], mdio};
			repeat (3) @(posedge clk);
		end
		// Clock parks low between frames
		@(posedge clk);
		mdc <= 1'b0;
		st_en <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	// Released fields show inverted junk so stale values never look valid
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask
	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h5a5a};
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 16'ha5a5};
		@(posedge clk);
		d = rdata;
	endtask
endmodule

/* dv/test_srm_rate_mgmt_top.sv */
// Self-checking bench for the rate and management register block
`timescale 1ns/1ps
`include "srm_defs.svh"
module test_srm_rate_mgmt_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	srm_pkg::srm_req_t hb_req;
	logic [15:0] hb_rdata, advertised_ability, rv;
	logic [15:0] partner_ability = 16'h0000;
	logic [15:0] an_expansion = 16'h0000;
	logic sgmii_phy_role = 1'b1;
	logic pcs_standard_select = 1'b0;
	logic link_up = 1'b1;
	logic an_complete = 1'b0;
	logic [1:0] operational_rate;
	logic channel_reset, an_restart, loopback, an_enable, power_down, isolate, mdio_oe_n;
	logic hb_mdio_o, md_mdc, md_line, md_o, md_oe_n, md_pdn;
	logic [4:0] md_addr = 5'h01;
	int errors = 0;
	int total_checks = 0;
	int cycles = 0;
	int rst_pulses = 0;
	int restart_pulses = 0;

	srm_rate_mgmt_top #(.HOST_BUS(1'b1)) srm_rate_mgmt_top_i (.clk(clk), .rst_n(rst_n), .mdc(1'b0),
		.mdio_i(1'b1), .mdio_o(hb_mdio_o), .mdio_oe_n(mdio_oe_n), .phy_addr(5'h00), .hb_req(hb_req),
		.hb_rdata(hb_rdata), .sgmii_phy_role(sgmii_phy_role), .pcs_standard_select(pcs_standard_select),
		.link_up(link_up), .an_complete(an_complete), .partner_ability(partner_ability),
		.an_expansion(an_expansion), .operational_rate(operational_rate), .channel_reset(channel_reset),
		.an_restart(an_restart), .loopback(loopback), .an_enable(an_enable), .power_down(power_down),
		.isolate(isolate), .advertised_ability(advertised_ability));
	srm_rate_mgmt_top #(.HOST_BUS(1'b0)) srm_rate_mgmt_top_mdio_i (.clk(clk), .rst_n(rst_n), .mdc(md_mdc),
		.mdio_i(md_line), .mdio_o(md_o), .mdio_oe_n(md_oe_n), .phy_addr(md_addr), .hb_req('0),
		.hb_rdata(), .sgmii_phy_role(sgmii_phy_role), .pcs_standard_select(pcs_standard_select),
		.link_up(link_up), .an_complete(an_complete), .partner_ability(partner_ability),
		.an_expansion(an_expansion), .operational_rate(), .channel_reset(), .an_restart(), .loopback(),
		.an_enable(), .power_down(md_pdn), .isolate(), .advertised_ability());
	srm_station_mgr srm_station_mgr_i (.clk(clk), .req(hb_req), .rdata(hb_rdata), .mdc(md_mdc),
		.mdio(md_line), .dev_o(md_o), .dev_oe_n(md_oe_n));

	always #50 clk = ~clk;
	// Pulses last one cycle, so they are counted here rather than polled
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (channel_reset === 1'b1) rst_pulses <= rst_pulses + 1;
		if (an_restart === 1'b1) restart_pulses <= restart_pulses + 1;
		if (cycles == 5000) begin
			errors++;
			complete_run;
		end
	end

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic rdchk(input logic [4:0] a, input logic [15:0] exp, input string name);
		srm_station_mgr_i.rd(a, rv);
		chk(name, exp, rv);
	endtask
	task automatic rate(input logic [1:0] exp, input string name);
		repeat (3) @(posedge clk);
		chk(name, {14'h0000, exp}, {14'h0000, operational_rate});
	endtask
	// Pins cross a two-flop synchroniser before reaching the resolver
	task automatic pins(input logic gbe, input logic phy);
		@(posedge clk);
		pcs_standard_select <= gbe;
		sgmii_phy_role <= phy;
		repeat (8) @(posedge clk);
	endtask

	task automatic test_reset_values;
		rdchk(`SRM_OFS_CTRL, 16'h1140, "ctrl reset");
		rdchk(`SRM_OFS_ADV, 16'h0801, "adv reset");
		rdchk(`SRM_OFS_EXT, 16'h8000, "ext status");
		chk("oe_n", 16'h0001, {15'h0000, mdio_oe_n});
		chk("mdio_o idle", 16'h0001, {15'h0000, hb_mdio_o});
		rate(2'b10, "rate reset");
	endtask
	task automatic test_manual_rate;
		logic [15:0] w;
		for (int i = 0; i < 4; i++) begin
			w = {2'b00, i[0], 6'h00, i[1], 6'h00};
			srm_station_mgr_i.wr(`SRM_OFS_CTRL, w);
			rate({w[6], w[13]}, "manual rate");
			rdchk(`SRM_OFS_CTRL, w, "speed readback");
		end
	endtask
	task automatic test_gbe;
		pins(1'b1, 1'b1);
		rate(2'b10, "gbe rate");
		srm_station_mgr_i.wr(`SRM_OFS_CTRL, 16'h2000);
		rdchk(`SRM_OFS_CTRL, 16'h0040, "gbe speed");
		rate(2'b10, "gbe manual");
		pins(1'b0, 1'b1);
		rate(2'b11, "sgmii manual kept");
	endtask
	task automatic test_an_rate;
		srm_station_mgr_i.wr(`SRM_OFS_CTRL, 16'h1000);
		srm_station_mgr_i.wr(`SRM_OFS_ADV, 16'h0400);
		rdchk(`SRM_OFS_ADV, 16'h0400, "adv write");
		rate(2'b01, "phy an rate");
		@(posedge clk);
		partner_ability <= 16'h0800;
		pins(1'b0, 1'b0);
		rate(2'b10, "mac an rate");
		chk("mac adv", 16'h4001, advertised_ability);
		srm_station_mgr_i.wr(`SRM_OFS_ADV, 16'h0000);
		pins(1'b0, 1'b1);
		rate(2'b01, "phy again");
		rdchk(`SRM_OFS_ADV, 16'h0400, "adv kept");
	endtask
	task automatic test_readonly;
		@(posedge clk);
		partner_ability <= 16'h1234;
		an_expansion <= 16'h0006;
		srm_station_mgr_i.wr(`SRM_OFS_LPA, 16'hffff);
		rdchk(`SRM_OFS_LPA, 16'h1234, "partner");
		rdchk(`SRM_OFS_EXP, 16'h0006, "expansion");
		rdchk(5'h02, 16'h0000, "unmapped");
	endtask
	task automatic test_self_clear;
		int b;
		b = restart_pulses;
		srm_station_mgr_i.wr(`SRM_OFS_CTRL, 16'h1200);
		repeat (3) @(posedge clk);
		chk("restart pulses", 16'h0001, 16'(restart_pulses - b));
		rdchk(`SRM_OFS_CTRL, 16'h1000, "restart clear");
		srm_station_mgr_i.wr(`SRM_OFS_CTRL, 16'h5c00);
		repeat (2) @(posedge clk);
		chk("levels", 16'h000f, {12'h000, loopback, an_enable, power_down, isolate});
		b = rst_pulses;
		srm_station_mgr_i.wr(`SRM_OFS_CTRL, 16'h8000);
		repeat (3) @(posedge clk);
		chk("reset pulses", 16'h0001, 16'(rst_pulses - b));
		rdchk(`SRM_OFS_CTRL, 16'h1140, "reset clear");
		chk("levels off", 16'h0004, {12'h000, loopback, an_enable, power_down, isolate});
	endtask
	task automatic test_link_latch;
		@(posedge clk);
		an_complete <= 1'b1;
		srm_station_mgr_i.rd(`SRM_OFS_STAT, rv);
		rdchk(`SRM_OFS_STAT, 16'h01ac, "status up");
		@(posedge clk);
		link_up <= 1'b0;
		@(posedge clk);
		link_up <= 1'b1;
		srm_station_mgr_i.rd(`SRM_OFS_STAT, rv);
		chk("link latched", 16'h0000, {15'h0000, rv[2]});
		srm_station_mgr_i.rd(`SRM_OFS_STAT, rv);
		chk("link cleared", 16'h0001, {15'h0000, rv[2]});
	endtask
	task automatic test_mdio;
		srm_station_mgr_i.mdio_xfer(1'b0, md_addr, `SRM_OFS_CTRL, 16'h0940, rv);
		chk("mdio power down", 16'h0001, {15'h0000, md_pdn});
		srm_station_mgr_i.mdio_xfer(1'b1, md_addr, `SRM_OFS_CTRL, 16'h0000, rv);
		chk("mdio ctrl read", 16'h0940, rv);
		chk("mdio released", 16'h0001, {15'h0000, md_oe_n});
		srm_station_mgr_i.mdio_xfer(1'b1, 5'h02, `SRM_OFS_CTRL, 16'h0000, rv);
		chk("mdio other address", 16'hffff, rv);
	endtask

	task automatic complete_run;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (10) @(posedge clk);
		test_reset_values();
		test_manual_rate();
		test_gbe();
		test_an_rate();
		test_readonly();
		test_self_clear();
		test_link_latch();
		test_mdio();
		complete_run();
	end
endmodule
